//--- rtl/spmc_regs.sv
// Purpose: status, enable, monitor and C/I0 registers of the serial port with its frame engine
// Assumes: classic wishbone slave, link pins sampled by mclk through two flops
// Notes: one frame is 32 link bits, monitor octet 2, C/I0 and handshake bits in octet 3
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Function
// [RULE1] reset: buffer-free flag set, others clear
// [RULE2] flags set regardless of enable bits
// [RULE3] status read clears bits 6, 3, 2
// [RULE4] tx write clears bit1, rx read bit0
// [RULE5] monitor disable clears flags 3 to 0
// [RULE6] timing request per master or slave mode
// [RULE7] power-down exit only when request unmasked
// [RULE8] C/I change flags on differing codes
// [RULE9] abort flag on far-end abort
// [RULE10] end-of-message flag from far end
// [RULE11] buffer-free flag when tx slot empties
// [RULE12] rx flag when byte lands in register
// [RULE13] one enable bit per status flag
// [RULE14] enable bit 7 gates all interrupts
// [RULE15] enable register reads 80 until written
// [RULE16] host toggles master enable around handler
// [RULE17] transmit written byte, idle all ones
// [RULE18] rx byte kept until software reads it
// [RULE19] C/I0 code sent every frame, idle default
// [RULE20] bus request with contention enabled
// [RULE21] C/I0 receive code stable two frames
// [RULE22] shared addresses split by direction
// [RULE23] monitor disabled forces FF and 00
// [RULE24] bus accessed held low while requested
// [RULE25] interrupt from enabled flag and master
module spmc_regs (
	input wire logic mclk,
	input wire logic rst_n,
	input wire spmc_pkg::spmc_wbreq_s wbIn,
	output logic wbAck,
	output logic [31:0] wbDatO,
	input wire spmc_pkg::spmc_link_s link,
	output logic linkDout,
	output logic linkDoe,
	output logic busAccessedInd,
	output logic powerDown,
	output logic portIrq
);
	// ----------------------------------------
	// state reset value
	// ----------------------------------------
	localparam spmc_pkg::spmc_state_s STATE_RST = '{
		sync1: 3'h0, sync2: 3'h0, sync3: 3'h0, ack: 1'b0, rdat: 8'h00, irq: 1'b0,
		bitCnt: 5'h00, rxSh: 8'h00, monLatch: 8'h00, txFrame: 32'hFFFF_FFFF, dout: 1'b1, doe: 1'b0,
		stat: spmc_pkg::STATUS_RST, ier: spmc_pkg::IER_RST, ierWr: 1'b0, ctrl: spmc_pkg::CTRL_RST,
		txByte: spmc_pkg::MON_TX_IDLE, txFull: 1'b0, sending: 1'b0, rxByte: spmc_pkg::MON_RX_RST,
		mrOut: 1'b1, prevMx: 1'b1, ciPrev: spmc_pkg::CI0_RX_IDLE, ciReg: spmc_pkg::CI0_RX_IDLE,
		ciLast: spmc_pkg::CI0_RX_IDLE, ci1Prev: spmc_pkg::CI1_RX_IDLE, ci1Reg: spmc_pkg::CI1_RX_IDLE,
		ciTx: spmc_pkg::CI0_TX_IDLE, bac: 1'b1, pd: 1'b0};

	spmc_pkg::spmc_state_s s_r;
	spmc_pkg::spmc_state_s s_nxt;

	function automatic logic hitIdx(input logic [7:0] idx, input logic [7:0] want);
		hitIdx = (idx == want);
	endfunction : hitIdx

	// ----------------------------------------
	// decode and link events
	// ----------------------------------------
	logic reqAcc;
	logic wrAcc;
	logic rdAcc;
	logic [7:0] idx;
	logic [7:0] wrByte;
	logic sclkRise;
	logic sclkFall;
	logic fscRise;
	logic dinS;
	logic [7:0] rxNew;
	logic frameEnd;
	logic monDone;
	logic ci1Done;
	logic monEn;
	logic iomMode;
	logic trEvent;
	logic monDisable;
	logic monEnable;

	assign reqAcc = wbIn.cyc & wbIn.stb & ~s_r.ack;
	assign wrAcc = reqAcc & wbIn.we & wbIn.sel[0];
	assign rdAcc = reqAcc & ~wbIn.we;
	assign idx = wbIn.adr[spmc_pkg::ADR_W-1:2];
	assign wrByte = wbIn.dat[7:0];
	// third stage only feeds edge detection, first stage stays private to the second
	assign sclkRise = s_r.sync2[0] & ~s_r.sync3[0];
	assign sclkFall = ~s_r.sync2[0] & s_r.sync3[0];
	assign fscRise = s_r.sync2[1] & ~s_r.sync3[1];
	assign dinS = s_r.sync2[2];
	assign rxNew = {s_r.rxSh[6:0], dinS};
	assign frameEnd = sclkRise & (s_r.bitCnt == spmc_pkg::BIT_FRAME_END);
	assign monDone = sclkRise & (s_r.bitCnt == spmc_pkg::BIT_MON_END);
	assign ci1Done = sclkRise & (s_r.bitCnt == spmc_pkg::BIT_CI1_END);
	assign monEn = s_r.ctrl[spmc_pkg::CTL_MONEN];
	assign iomMode = s_r.ctrl[1];
	assign monDisable = wrAcc & hitIdx(idx, spmc_pkg::IDX_CTRL) & monEn & ~wrByte[spmc_pkg::CTL_MONEN];
	assign monEnable = wrAcc & hitIdx(idx, spmc_pkg::IDX_CTRL) & ~monEn & wrByte[spmc_pkg::CTL_MONEN];
	// master sees the downstream pull-low, slave sees clocks start while deactivated
	assign trEvent = ~s_r.ctrl[spmc_pkg::CTL_ACTIVE] &
		(((s_r.ctrl[1:0] == spmc_pkg::MODE_MASTER) & ~dinS) |
		((s_r.ctrl[1:0] == spmc_pkg::MODE_SLAVE) & sclkRise)); // [RULE6]

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [7:0] setV;
		logic [7:0] clrV;
		logic accepted;
		logic [7:0] monOct;
		logic [31:0] frameNew;
		setV = 8'h00;
		clrV = 8'h00;
		accepted = 1'b0;
		monOct = spmc_pkg::MON_TX_IDLE;
		frameNew = 32'hFFFF_FFFF;
		s_nxt = s_r;
		s_nxt.sync1 = {link.din, link.fsc, link.sclk};
		s_nxt.sync2 = s_r.sync1;
		s_nxt.sync3 = s_r.sync2;
		s_nxt.ack = reqAcc;
		s_nxt.doe = iomMode;

		// link frame engine
		if (sclkRise) begin
			s_nxt.bitCnt = s_r.bitCnt + 5'd1;
			s_nxt.rxSh = rxNew;
		end
		if (sclkFall) begin
			s_nxt.dout = s_r.txFrame[~s_r.bitCnt];
		end
		if (monDone) begin
			s_nxt.monLatch = rxNew;
		end
		if (ci1Done) begin
			s_nxt.ci1Prev = rxNew[7:2];
			if (rxNew[7:2] == s_r.ci1Prev && rxNew[7:2] != s_r.ci1Reg) begin
				s_nxt.ci1Reg = rxNew[7:2];
				setV[spmc_pkg::ST_CODE1] = 1'b1; // [RULE8]
			end
		end
		if (frameEnd) begin
			s_nxt.ciPrev = rxNew[5:2];
			if (rxNew[5:2] == s_r.ciPrev) begin
				s_nxt.ciReg = rxNew[5:2]; // [RULE21]
			end
			if (monEn) begin
				if (!rxNew[0] && !s_r.stat[spmc_pkg::ST_RXWAIT]) begin
					s_nxt.rxByte = s_r.monLatch; // [RULE18]
					setV[spmc_pkg::ST_RXWAIT] = 1'b1; // [RULE12]
					accepted = 1'b1;
				end
				if (rxNew[0] && !s_r.prevMx) begin
					setV[spmc_pkg::ST_EOM] = 1'b1; // [RULE10]
				end
				if (s_r.sending) begin
					setV[spmc_pkg::ST_TXFREE] = 1'b1; // [RULE11]
					setV[spmc_pkg::ST_ABORT] = rxNew[1]; // [RULE9]
				end
			end
			s_nxt.sending = 1'b0;
			s_nxt.prevMx = rxNew[0];
			s_nxt.mrOut = ~accepted;
		end
		if (fscRise) begin
			monOct = s_r.txFull ? s_r.txByte : spmc_pkg::MON_TX_IDLE;
			frameNew = {16'hFFFF, monOct, 2'b11, s_r.ciTx[3:0], s_r.mrOut, ~s_r.txFull}; // [RULE17] [RULE19]
			s_nxt.txFrame = frameNew;
			s_nxt.dout = frameNew[31];
			s_nxt.bitCnt = 5'd0;
			s_nxt.sending = s_r.txFull;
			s_nxt.txFull = 1'b0;
			s_nxt.txByte = spmc_pkg::MON_TX_IDLE;
		end

		// status flag sources, none of them looks at an enable bit
		setV[spmc_pkg::ST_TIMEREQ] = trEvent; // [RULE2]
		setV[spmc_pkg::ST_TXFREE] = setV[spmc_pkg::ST_TXFREE] | monEnable;
		if (trEvent && s_r.ier[spmc_pkg::ST_TIMEREQ]) begin
			s_nxt.pd = 1'b0; // [RULE7]
		end

		// bus writes
		if (wrAcc) begin
			unique case (1'b1)
				hitIdx(idx, spmc_pkg::IDX_CTRL): begin
					s_nxt.ctrl = {1'b0, wrByte[6:0]};
					if (wrByte[spmc_pkg::CTL_PDREQ]) begin
						s_nxt.pd = 1'b1;
					end
				end
				hitIdx(idx, spmc_pkg::IDX_IER): begin
					s_nxt.ier = wrByte; // [RULE13]
					s_nxt.ierWr = 1'b1;
				end
				hitIdx(idx, spmc_pkg::IDX_MON): begin
					if (monEn) begin
						s_nxt.txByte = wrByte; // [RULE22]
						s_nxt.txFull = 1'b1;
					end
					clrV[spmc_pkg::ST_TXFREE] = 1'b1; // [RULE4]
				end
				hitIdx(idx, spmc_pkg::IDX_CI0): begin
					s_nxt.ciTx = wrByte; // [RULE22]
				end
				default: begin
				end
			endcase
		end

		// bus reads, answer latched with the ack
		if (rdAcc) begin
			unique case (1'b1)
				hitIdx(idx, spmc_pkg::IDX_STATUS): begin
					s_nxt.rdat = s_r.stat;
					clrV[spmc_pkg::ST_TIMEREQ] = 1'b1; // [RULE3]
					clrV[spmc_pkg::ST_ABORT] = 1'b1; // [RULE3]
					clrV[spmc_pkg::ST_EOM] = 1'b1; // [RULE3]
					clrV[spmc_pkg::ST_CODE1] = 1'b1;
				end
				hitIdx(idx, spmc_pkg::IDX_IER): begin
					s_nxt.rdat = s_r.ierWr ? s_r.ier : spmc_pkg::IER_READ_RST; // [RULE15]
				end
				hitIdx(idx, spmc_pkg::IDX_MON): begin
					s_nxt.rdat = s_r.rxByte; // [RULE22]
					clrV[spmc_pkg::ST_RXWAIT] = 1'b1; // [RULE4]
				end
				hitIdx(idx, spmc_pkg::IDX_CI0): begin
					s_nxt.rdat = {4'h0, s_r.ciReg}; // [RULE22]
					s_nxt.ciLast = s_r.ciReg;
				end
				hitIdx(idx, spmc_pkg::IDX_CTRL): begin
					s_nxt.rdat = s_r.ctrl;
				end
				default: begin
					s_nxt.rdat = 8'h00;
				end
			endcase
		end

		if (monDisable) begin
			clrV[3:0] = 4'hF; // [RULE5]
		end
		// set beats clear so an event in the clearing cycle survives
		s_nxt.stat = (s_r.stat & ~clrV) | setV; // [RULE2]
		s_nxt.stat[spmc_pkg::ST_CODE0] = (s_r.ciReg != s_r.ciLast); // [RULE8]
		s_nxt.stat[7] = 1'b0;

		if (!monEn) begin
			s_nxt.txByte = spmc_pkg::MON_TX_IDLE; // [RULE23]
			s_nxt.rxByte = spmc_pkg::MON_RX_RST; // [RULE23]
			s_nxt.txFull = 1'b0;
		end
		if (s_r.ctrl[1:0] == spmc_pkg::MODE_OFF) begin
			s_nxt.ciTx = spmc_pkg::CI0_TX_IDLE; // [RULE19]
			s_nxt.ciReg = spmc_pkg::CI0_RX_IDLE; // [RULE21]
			s_nxt.ciLast = spmc_pkg::CI0_RX_IDLE;
		end
		// ownership taken as won; request bit holds the channel until cleared
		s_nxt.bac = ~(s_r.ctrl[spmc_pkg::CTL_TICEN] & s_r.ciTx[spmc_pkg::CI_BUSREQ] & iomMode); // [RULE20] [RULE24]
		s_nxt.irq = s_r.ier[spmc_pkg::IER_MASTER] & (|(s_r.stat[6:0] & s_r.ier[6:0])); // [RULE14] [RULE25]
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= STATE_RST; // [RULE1]
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wbAck = s_r.ack;
	assign wbDatO = {24'h00_0000, s_r.rdat};
	assign linkDout = s_r.dout;
	assign linkDoe = s_r.doe;
	assign busAccessedInd = s_r.bac;
	assign powerDown = s_r.pd;
	assign portIrq = s_r.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence busReqS;
		wbIn.cyc && wbIn.stb && !s_r.ack;
	endsequence
	sequence statusReadS;
		rdAcc && hitIdx(idx, spmc_pkg::IDX_STATUS) && !trEvent && !frameEnd;
	endsequence
	sequence disableThenIdleS;
		(s_r.stat[3:0] == 4'h0) ##1 (s_r.txByte == 8'hFF && s_r.rxByte == 8'h00);
	endsequence

	wb_ack_once_a: assert property (busReqS |=> wbAck ##1 !wbAck)
		else $error("ack not a single pulse one cycle after request");
	status_read_clear_a: assert property (statusReadS |=> s_r.stat[6] == 1'b0 && s_r.stat[3:2] == 2'b00) // [RULE3]
		else $error("status read left clear-on-read flags set");
	tx_write_clear_a: assert property (wrAcc && hitIdx(idx, spmc_pkg::IDX_MON) && !frameEnd |=> !s_r.stat[1]) // [RULE4]
		else $error("tx write did not clear buffer-free flag");
	rx_read_clear_a: assert property (rdAcc && hitIdx(idx, spmc_pkg::IDX_MON) && !frameEnd |=> !s_r.stat[0]) // [RULE4]
		else $error("rx read did not clear data flag");
	mon_disable_a: assert property (monDisable && !frameEnd |=> disableThenIdleS) // [RULE5]
		else $error("monitor disable did not clear flags and registers");
	irq_gate_a: assert property (s_r.ier[7] && (s_r.stat[6:0] & s_r.ier[6:0]) != 7'h00 |=> portIrq) // [RULE25]
		else $error("enabled flag did not raise interrupt");
	master_off_a: assert property (!s_r.ier[7] |=> !portIrq) // [RULE14]
		else $error("interrupt raised with master enable clear");
	pd_masked_a: assert property (s_r.pd && !s_r.ier[6] && !wrAcc |=> s_r.pd) // [RULE7]
		else $error("left power-down with request masked");
	bac_hold_a: assert property ((s_r.ctrl[3] && s_r.ciTx[7] && s_r.ctrl[1])[*2] |-> !busAccessedInd) // [RULE24]
		else $error("bus accessed released while request held");
	rx_keep_a: assert property (s_r.ctrl[6] && s_r.stat[0] && !(rdAcc && hitIdx(idx, spmc_pkg::IDX_MON))
		|=> $stable(s_r.rxByte)) // [RULE18]
		else $error("unread rx byte overwritten");
	ci_idle_a: assert property (s_r.ctrl[1:0] == 2'b00 |=> s_r.ciTx == 8'h0F && s_r.ciReg == 4'hF) // [RULE19]
		else $error("disabled port did not restore C/I0 defaults");
	frame_start_a: assert property (fscRise |=> s_r.bitCnt == 5'd0)
		else $error("frame sync did not restart bit count");

	// ----------------------------------------
	// frame end and register path checks
	// ----------------------------------------
	sequence frameEndS;
		frameEnd && monEn;
	endsequence
	sequence rxTakeS;
		frameEndS ##0 (!rxNew[0] && !s_r.stat[spmc_pkg::ST_RXWAIT]);
	endsequence
	sequence sentEndS;
		frameEndS ##0 s_r.sending;
	endsequence

	rx_land_a: assert property (rxTakeS |=> s_r.stat[0] && s_r.rxByte == $past(s_r.monLatch)) // [RULE12]
		else $error("accepted rx byte not loaded with flag");
	rx_ack_a: assert property (rxTakeS |=> !s_r.mrOut) // [RULE18]
		else $error("accepted rx byte not acknowledged next frame");
	eom_set_a: assert property (frameEndS ##0 (rxNew[0] && !s_r.prevMx) |=> s_r.stat[2]) // [RULE10]
		else $error("end of message not flagged");
	abort_set_a: assert property (sentEndS ##0 rxNew[1] |=> s_r.stat[3]) // [RULE9]
		else $error("far-end abort not flagged");
	txfree_set_a: assert property (sentEndS |=> s_r.stat[1]) // [RULE11]
		else $error("sent byte did not free the tx slot");
	timereq_set_a: assert property (trEvent |=> s_r.stat[6]) // [RULE2] [RULE6]
		else $error("timing request not flagged");
	pd_exit_a: assert property (trEvent && s_r.ier[6] && !(wrAcc && hitIdx(idx, spmc_pkg::IDX_CTRL)) |=> !s_r.pd) // [RULE7]
		else $error("unmasked timing request did not leave power-down");
	ci0_stable_a: assert property (frameEnd && rxNew[5:2] == s_r.ciPrev && s_r.ctrl[1:0] != spmc_pkg::MODE_OFF
		|=> s_r.ciReg == $past(rxNew[5:2])) // [RULE21]
		else $error("code valid two frames not presented");
	ci_tx_frame_a: assert property (fscRise |=> s_r.txFrame[5:2] == $past(s_r.ciTx[3:0])) // [RULE19]
		else $error("frame does not carry the C/I0 code");
	mon_write_a: assert property (wrAcc && hitIdx(idx, spmc_pkg::IDX_MON) && monEn
		|=> s_r.txFull && s_r.txByte == $past(wrByte)) // [RULE17] [RULE22]
		else $error("monitor write did not reach tx byte");
	ier_write_a: assert property (wrAcc && hitIdx(idx, spmc_pkg::IDX_IER) |=> s_r.ier == $past(wrByte) && s_r.ierWr) // [RULE13]
		else $error("enable write not stored");
	ier_read_rst_a: assert property (rdAcc && hitIdx(idx, spmc_pkg::IDX_IER) && !s_r.ierWr
		|=> wbDatO[7:0] == spmc_pkg::IER_READ_RST) // [RULE15]
		else $error("unwritten enable register read wrong");
	rx_read_data_a: assert property (rdAcc && hitIdx(idx, spmc_pkg::IDX_MON) |=> wbDatO[7:0] == $past(s_r.rxByte)) // [RULE22]
		else $error("monitor read did not return rx byte");
	ci_read_data_a: assert property (rdAcc && hitIdx(idx, spmc_pkg::IDX_CI0) |=> wbDatO[3:0] == $past(s_r.ciReg)) // [RULE22]
		else $error("C/I0 read did not return receive code");
	rdata_hold_a: assert property (!rdAcc |=> $stable(wbDatO))
		else $error("read data changed without a read");
	code1_set_a: assert property (ci1Done && rxNew[7:2] == s_r.ci1Prev && rxNew[7:2] != s_r.ci1Reg |=> s_r.stat[5]) // [RULE8]
		else $error("C/I1 change not flagged");
	mon_off_idle_a: assert property (!monEn |=> s_r.txByte == spmc_pkg::MON_TX_IDLE && s_r.rxByte == spmc_pkg::MON_RX_RST) // [RULE23]
		else $error("disabled monitor registers not idle");
endmodule : spmc_regs

//--- rtl/spmc_pkg.sv
// Purpose: shared constants and types for the serial port monitor and C/I0 register bank
// Assumes: register index times four gives the wishbone byte address
// Notes: link pins arrive asynchronous and are synchronised inside the bank
package spmc_pkg;
	// ----------------------------------------
	// register indices
	// ----------------------------------------
	localparam int ADR_W = 10;
	localparam logic [7:0] IDX_STATUS = 8'hC1;
	localparam logic [7:0] IDX_IER = 8'hC2;
	localparam logic [7:0] IDX_MON = 8'hC3;
	localparam logic [7:0] IDX_CI0 = 8'hC4;
	localparam logic [7:0] IDX_CTRL = 8'hD0;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ST_TIMEREQ = 6;
	localparam int ST_CODE1 = 5;
	localparam int ST_CODE0 = 4;
	localparam int ST_ABORT = 3;
	localparam int ST_EOM = 2;
	localparam int ST_TXFREE = 1;
	localparam int ST_RXWAIT = 0;
	localparam int IER_MASTER = 7;
	localparam int CTL_PDREQ = 7;
	localparam int CTL_MONEN = 6;
	localparam int CTL_TICEN = 3;
	localparam int CTL_ACTIVE = 2;
	localparam int CI_BUSREQ = 7;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SLAVE = 2'h2;
	localparam logic [1:0] MODE_MASTER = 2'h3;
	// ----------------------------------------
	// reset values and frame layout
	// ----------------------------------------
	localparam logic [7:0] STATUS_RST = 8'h02;
	localparam logic [7:0] IER_RST = 8'h00;
	localparam logic [7:0] IER_READ_RST = 8'h80;
	localparam logic [7:0] CTRL_RST = 8'h01;
	localparam logic [7:0] MON_TX_IDLE = 8'hFF;
	localparam logic [7:0] MON_RX_RST = 8'h00;
	localparam logic [7:0] CI0_TX_IDLE = 8'h0F;
	localparam logic [3:0] CI0_RX_IDLE = 4'hF;
	localparam logic [5:0] CI1_RX_IDLE = 6'h3F;
	localparam logic [4:0] BIT_CI1_END = 5'd15;
	localparam logic [4:0] BIT_MON_END = 5'd23;
	localparam logic [4:0] BIT_FRAME_END = 5'd31;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADR_W-1:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} spmc_wbreq_s;

	typedef struct packed {
		logic sclk;
		logic fsc;
		logic din;
	} spmc_link_s;

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] sync3;
		logic ack;
		logic [7:0] rdat;
		logic irq;
		logic [4:0] bitCnt;
		logic [7:0] rxSh;
		logic [7:0] monLatch;
		logic [31:0] txFrame;
		logic dout;
		logic doe;
		logic [7:0] stat;
		logic [7:0] ier;
		logic ierWr;
		logic [7:0] ctrl;
		logic [7:0] txByte;
		logic txFull;
		logic sending;
		logic [7:0] rxByte;
		logic mrOut;
		logic prevMx;
		logic [3:0] ciPrev;
		logic [3:0] ciReg;
		logic [3:0] ciLast;
		logic [5:0] ci1Prev;
		logic [5:0] ci1Reg;
		logic [7:0] ciTx;
		logic bac;
		logic pd;
	} spmc_state_s;
endpackage : spmc_pkg

//--- testbench/spmc_link_model.sv
// Purpose: far-end link partner that clocks whole frames into the serial port
// Assumes: bit clock of 125 ns, standing still low between frames
// Notes: data line has no pull, so between frames it shows the inverse of the last bit
`timescale 1ns/1ps
module spmc_link_model (
	output spmc_pkg::spmc_link_s link,
	input wire logic dout
);
	initial begin
		link = '{sclk: 1'b0, fsc: 1'b0, din: 1'b1};
	end
	// ----------------------------------------
	// one frame, msb first; our bits captured at each rising bit clock
	// ----------------------------------------
	task automatic send(input logic [31:0] f, output logic [31:0] cap);
		link.fsc = 1'b1;
		for (int i = 31; i >= 0; i--) begin
			link.din = f[i];
			#62.5 link.sclk = 1'b1;
			cap[i] = dout;
			#62.5 link.sclk = 1'b0;
			if (i == 30) begin
				link.fsc = 1'b0;
			end
		end
		link.din = ~f[0];
		// gap lets the frame-end work land before the host looks
		#250;
	endtask : send
	// ----------------------------------------
	// static line level for clock-start requests
	// ----------------------------------------
	task automatic hold_din(input logic v);
		link.din = v;
	endtask : hold_din
endmodule : spmc_link_model

//--- testbench/tb.sv
// Purpose: self-checking bench for the serial port register bank
// Assumes: classic wishbone host, link partner model on the far side
// Notes: scenarios run in order and rely on the flag state left by the one before
`timescale 1ns/1ps
module tb;
	logic mclk;
	logic rst_n;
	spmc_pkg::spmc_wbreq_s wbIn;
	logic wbAck;
	logic [31:0] wbDatO;
	spmc_pkg::spmc_link_s link;
	logic linkDout;
	logic linkDoe;
	logic busAccessedInd;
	logic powerDown;
	logic portIrq;
	int n_fail;
	int tests_run;
	logic [31:0] cap;

	spmc_regs u_dut (.mclk(mclk), .rst_n(rst_n), .wbIn(wbIn), .wbAck(wbAck), .wbDatO(wbDatO), .link(link),
		.linkDout(linkDout), .linkDoe(linkDoe), .busAccessedInd(busAccessedInd), .powerDown(powerDown),
		.portIrq(portIrq));
	spmc_link_model u_far (.link(link), .dout(linkDout));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// ack is read in the active region of the edge, so it is the value that edge sampled
	// no local limit: a slave that never acks is caught by the watchdog
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk);
		wbIn <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h00_0000, d}};
		do begin
			@(posedge mclk);
		end while (wbAck !== 1'b1);
		q = wbDatO[7:0];
		wbIn.cyc <= 1'b0;
		wbIn.stb <= 1'b0;
	endtask : wb
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask : wr
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string nm);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk(nm, exp, q);
	endtask : rdc
	function automatic logic [31:0] mkf(input logic [7:0] mon, input logic [3:0] ci, input logic mr, input logic mx);
		return {16'hFFFF, mon, 2'b11, ci, mr, mx};
	endfunction : mkf
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdc(8'hC1, spmc_pkg::STATUS_RST, "status");
		rdc(8'hC2, spmc_pkg::IER_READ_RST, "enables");
		rdc(8'hC3, spmc_pkg::MON_RX_RST, "monRx");
		rdc(8'hC4, {4'h0, spmc_pkg::CI0_RX_IDLE}, "ci0Rx");
		chk("busAcc", 8'h01, {7'h00, busAccessedInd});
	endtask : t_reset
	task automatic t_enables;
		wr(8'hD0, 8'h47);
		wr(8'hC2, 8'h55);
		rdc(8'hC2, 8'h55, "enables");
		wr(8'hC2, 8'h00);
		chk("doe", 8'h01, {7'h00, linkDoe});
	endtask : t_enables
	task automatic t_tx;
		wr(8'hC3, 8'hA5);
		rdc(8'hC1, 8'h00, "status");
		u_far.send(mkf(8'hFF, 4'hF, 1'b0, 1'b1), cap);
		chk("txOctet", 8'hA5, cap[15:8]);
		chk("txValid", 8'h00, {7'h00, cap[0]});
		chk("txCode", 8'h0F, {4'h0, cap[5:2]});
		rdc(8'hC1, 8'h02, "status");
	endtask : t_tx
	task automatic t_abort;
		wr(8'hC3, 8'h5A);
		u_far.send(mkf(8'hFF, 4'hF, 1'b1, 1'b1), cap);
		rdc(8'hC1, 8'h0A, "status");
		rdc(8'hC1, 8'h02, "status");
	endtask : t_abort
	task automatic t_rx;
		u_far.send(mkf(8'h3C, 4'hF, 1'b1, 1'b0), cap);
		rdc(8'hC1, 8'h03, "status");
		wr(8'hC2, 8'h81);
		tick(3);
		chk("irq", 8'h01, {7'h00, portIrq});
		wr(8'hC2, 8'h01);
		tick(3);
		chk("irq", 8'h00, {7'h00, portIrq});
		u_far.send(mkf(8'h77, 4'hF, 1'b1, 1'b0), cap);
		chk("ourAck", 8'h00, {7'h00, cap[1]});
		u_far.send(mkf(8'h00, 4'hF, 1'b1, 1'b1), cap);
		rdc(8'hC1, 8'h07, "status");
		rdc(8'hC3, 8'h3C, "monRx");
		rdc(8'hC1, 8'h02, "status");
	endtask : t_rx
	// octet 1 carries a C/I1 code of 15 in both frames, so its change flag rises too
	task automatic t_ci;
		wr(8'hC4, 8'h03);
		u_far.send(mkf(8'hFF, 4'h5, 1'b1, 1'b1) & 32'hFF57_FFFF, cap);
		rdc(8'hC4, 8'h0F, "ci0Rx");
		u_far.send(mkf(8'hFF, 4'h5, 1'b1, 1'b1) & 32'hFF57_FFFF, cap);
		chk("txCode", 8'h03, {4'h0, cap[5:2]});
		rdc(8'hC1, 8'h32, "status");
		rdc(8'hC4, 8'h05, "ci0Rx");
		rdc(8'hC1, 8'h02, "status");
	endtask : t_ci
	task automatic t_bus;
		wr(8'hD0, 8'h4F);
		wr(8'hC4, 8'h83);
		tick(3);
		chk("busAcc", 8'h00, {7'h00, busAccessedInd});
		tick(20);
		chk("busAcc", 8'h00, {7'h00, busAccessedInd});
		wr(8'hC4, 8'h03);
		tick(3);
		chk("busAcc", 8'h01, {7'h00, busAccessedInd});
	endtask : t_bus
	task automatic t_mondis;
		u_far.send(mkf(8'h11, 4'h5, 1'b1, 1'b0), cap);
		wr(8'hD0, 8'h0F);
		rdc(8'hC1, 8'h00, "status");
		rdc(8'hC3, 8'h00, "monRx");
		u_far.send(mkf(8'hFF, 4'h5, 1'b1, 1'b1), cap);
		chk("txOctet", 8'hFF, cap[15:8]);
		rdc(8'hC1, 8'h20, "status");
	endtask : t_mondis
	task automatic t_pd;
		u_far.hold_din(1'b1);
		wr(8'hC2, 8'h00);
		wr(8'hD0, 8'h83);
		tick(5);
		u_far.hold_din(1'b0);
		tick(10);
		chk("pd", 8'h01, {7'h00, powerDown});
		rdc(8'hC1, 8'h40, "status");
		u_far.hold_din(1'b1);
		wr(8'hC2, 8'h40);
		u_far.hold_din(1'b0);
		tick(10);
		chk("pd", 8'h00, {7'h00, powerDown});
	endtask : t_pd
	// slave mode sees clocks start, then the port is switched off
	task automatic t_modes;
		wr(8'hD0, 8'h02);
		rdc(8'hC1, 8'h40, "status");
		rdc(8'hC1, 8'h00, "status");
		u_far.send(mkf(8'hFF, 4'hF, 1'b1, 1'b1), cap);
		rdc(8'hC1, 8'h40, "status");
		wr(8'hD0, 8'h00);
		rdc(8'hC4, {4'h0, spmc_pkg::CI0_RX_IDLE}, "ci0Rx");
		wr(8'hC4, 8'h03);
		u_far.send(mkf(8'hFF, 4'hF, 1'b1, 1'b1), cap);
		chk("txCode", spmc_pkg::CI0_TX_IDLE, {4'h0, cap[5:2]});
		chk("doe", 8'h00, {7'h00, linkDoe});
	endtask : t_modes
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		wbIn = '0;
		n_fail = 0;
		tests_run = 0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset;
		t_enables;
		t_tx;
		t_abort;
		t_rx;
		t_ci;
		t_bus;
		t_mondis;
		t_pd;
		t_modes;
		close_out;
	end
	// about a dozen frames of 4 us each; generous margin for a hung handshake
	initial begin
		#200000;
		$display("MISMATCH watchdog expected done seen hang");
		n_fail++;
		close_out;
	end
endmodule : tb
